// ---- hw/reset_wake_tick_watchdog.sv ----
// Reset sources, wake decisions, 8-bit tick counter with prescaler, watchdog with prescaler.
// Assumes all inputs synchronous to mclk_i; sub-oscillator edges arrive as one-cycle strobes.
//
// Operation
// - Writing the tick counter clears its prescaler.
// - Watchdog-clear or enter-sleep instruction clears the watchdog prescaler.
// - Tick counter is 8-bit up-counter, source and external edge selectable.
// - Internal source without prescaling counts once per instruction cycle.
// - External source counts each selected rising or falling pin edge.
// - Two separate 8-bit prescalers, each with own three-bit ratio select.
// - Watchdog runs from sub-oscillator, independent of main oscillator.
// - Enabled watchdog expiry resets outside sleep; ignored in sleep.
// - Watchdog enable bit writes take effect immediately.
// - Timeout equals prescale ratio times 256 periods of half sub-oscillator.
// - Reset from power-on, watchdog, enabled low-voltage, or low reset pin.
// - Reset keeps oscillator running and forces program counter to zero.
// - Reset sets all port direction bits, making pins inputs.
// - Reset clears tick counter, watchdog counter and both prescalers.
// - Power-on clears status bits 5,6 and top two bank-select bits.
// - Reset sets tick control to 0xBF, all ones but the global-interrupt bit, which reads zero.
// - Port-change wake keeps registers, then jumps to 0x0018 or continues.
// - Tick overflow interrupts only in running modes, never wakes.
// - External pin edges wake from sleep or idle and interrupt.
// - Timer underflows wake from idle only, interrupt in idle and running modes; nothing in sleep.
// - Port change wakes from sleep/idle; interrupts only if mask bit 7.
// - Ports 6 and 8 detect input changes for change events.
// - Tick source, edge and prescaler-assign bits; ratios 1:2 to 1:256.
// - Watchdog prescale codes give ratios 1:1 to 1:128.
// - Four active-high bits disable change wake per port nibble.
// - Each mask bit enables its interrupt source when one.
`timescale 1ns/1ps
`default_nettype none

module reset_wake_tick_watchdog (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Core register port and instructions
	input wire reset_wake_tick_watchdog_pkg::reg_req_t req_i,
	input wire logic instr_tick_i,
	input wire logic wdt_clr_instr_i,
	input wire logic sleep_instr_i,
	input wire logic gie_i,
	input wire reset_wake_tick_watchdog_pkg::op_mode_t mode_i,
	output logic [7:0] rdata_o,
	output reset_wake_tick_watchdog_pkg::core_ctl_t ctl_o,
	// Reset sources
	input wire logic ext_reset_n_i,
	input wire logic low_voltage_det_i,
	input wire logic low_voltage_reset_en_i,
	// Clocks and pins
	input wire logic sub_osc_tick_i,
	input wire logic tick_pin_i,
	input wire logic ext_irq_zero_i,
	input wire logic ext_irq_one_i,
	input wire logic [3:0] timer_underflow_i,
	input wire logic [7:0] port6_i,
	input wire logic [7:0] port8_i
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] ratio_mask(input logic [3:0] shift);
		logic [8:0] one;
		one = 9'h001;
		ratio_mask = 8'((one << shift) - one);
	endfunction : ratio_mask

	function automatic logic reg_hit(input reset_wake_tick_watchdog_pkg::reg_req_t r,
			input logic ioc, input logic page, input logic [3:0] addr);
		reg_hit = (r.ioc == ioc) && (!ioc || r.page == page) && (r.addr == addr);
	endfunction : reg_hit

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] tick_count_q, tick_pre_q, tick_ctrl_q, wdog_ctrl_q, wake_ctrl_q;
	logic [7:0] int_mask_q, int_flags_q, wdt_pre_q, wdt_cnt_q, rdata_q;
	logic [15:0] port_prev_q;
	logic [1:0] ext_prev_q;
	logic pin_s1_q, pin_s2_q, pin_s3_q, half_q, reset_q, por_q, osc_run_q;
	reset_wake_tick_watchdog_pkg::core_ctl_t ctl_q;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire clr = srst_i | reset_q;
	wire wr_tick = req_i.wr & reg_hit(req_i, 1'b0, 1'b0, reset_wake_tick_watchdog_pkg::ADDR_TICK_COUNT);
	wire wr_flags = req_i.wr & reg_hit(req_i, 1'b0, 1'b0, reset_wake_tick_watchdog_pkg::ADDR_INT_FLAGS);
	wire wr_mask = req_i.wr & reg_hit(req_i, 1'b1, 1'b0, reset_wake_tick_watchdog_pkg::ADDR_INT_MASK);
	wire wr_wake = req_i.wr & reg_hit(req_i, 1'b1, 1'b1, reset_wake_tick_watchdog_pkg::ADDR_WAKE_CTRL);
	wire wr_tctl = req_i.wr & reg_hit(req_i, 1'b1, 1'b1, reset_wake_tick_watchdog_pkg::ADDR_TICK_CTRL);
	wire wr_wctl = req_i.wr & reg_hit(req_i, 1'b1, 1'b1, reset_wake_tick_watchdog_pkg::ADDR_WDOG_CTRL);
	wire running = (mode_i == reset_wake_tick_watchdog_pkg::MODE_NORMAL)
		| (mode_i == reset_wake_tick_watchdog_pkg::MODE_GREEN);
	wire in_idle = (mode_i == reset_wake_tick_watchdog_pkg::MODE_IDLE);
	wire in_sleep = (mode_i == reset_wake_tick_watchdog_pkg::MODE_SLEEP);

	// ----------------------------------------------------------------
	// Tick counter path
	// ----------------------------------------------------------------
	// Only the second and third sync stages feed the edge detector
	wire pin_rise = pin_s2_q & ~pin_s3_q;
	wire pin_fall = ~pin_s2_q & pin_s3_q;
	wire pin_edge = tick_ctrl_q[reset_wake_tick_watchdog_pkg::TC_EDGE] ? pin_fall : pin_rise;
	wire tick_evt = tick_ctrl_q[reset_wake_tick_watchdog_pkg::TC_SRC] ? pin_edge : instr_tick_i;
	wire [2:0] tick_sel = tick_ctrl_q[reset_wake_tick_watchdog_pkg::PSEL_HI:reset_wake_tick_watchdog_pkg::PSEL_LO];
	// Prescaler off means shift 0 (1:1); codes 0..7 give 1:2..1:256
	wire [3:0] tick_shift = tick_ctrl_q[reset_wake_tick_watchdog_pkg::TC_PRESCALER_ASSIGN_BIT] ?
		({1'b0, tick_sel} + 4'h1) : 4'h0;
	wire [7:0] tick_mask = ratio_mask(tick_shift);
	wire tick_inc = tick_evt & ((tick_pre_q & tick_mask) == tick_mask);
	wire tick_ovf = tick_inc & ~wr_tick & (tick_count_q == reset_wake_tick_watchdog_pkg::FULL_BYTE);

	// ----------------------------------------------------------------
	// Watchdog path
	// ----------------------------------------------------------------
	wire fs_half_tick = sub_osc_tick_i & half_q;
	wire [2:0] wdt_sel = wdog_ctrl_q[reset_wake_tick_watchdog_pkg::PSEL_HI:reset_wake_tick_watchdog_pkg::PSEL_LO];
	wire [7:0] wdt_mask = ratio_mask({1'b0, wdt_sel});
	wire wdt_en = wdog_ctrl_q[reset_wake_tick_watchdog_pkg::WD_EN];
	wire wdt_pre_clr = wdt_clr_instr_i | sleep_instr_i;
	wire wdt_step = fs_half_tick & ((wdt_pre_q & wdt_mask) == wdt_mask) & ~wdt_pre_clr;
	wire wdt_expire = wdt_en & ~in_sleep & wdt_step
		& (wdt_cnt_q == reset_wake_tick_watchdog_pkg::FULL_BYTE);
	wire lv_reset = low_voltage_det_i & low_voltage_reset_en_i;
	wire rst_cause = ~ext_reset_n_i | lv_reset | wdt_expire;

	// ----------------------------------------------------------------
	// Wake and interrupt sources
	// ----------------------------------------------------------------
	wire ext_irq_zero_rise = ext_irq_zero_i & ~ext_prev_q[0];
	wire ext_irq_zero_fall = ~ext_irq_zero_i & ext_prev_q[0];
	wire ext_irq_zero_evt = tick_ctrl_q[reset_wake_tick_watchdog_pkg::TC_INT_EDGE] ? ext_irq_zero_fall : ext_irq_zero_rise;
	wire ext_irq_one_evt = ~ext_irq_one_i & ext_prev_q[1];
	wire [15:0] port_now = {port8_i, port6_i};
	wire [15:0] port_diff = port_now ^ port_prev_q;
	wire [3:0] nib_chg = {|port_diff[15:12], |port_diff[11:8], |port_diff[7:4], |port_diff[3:0]};
	wire port_evt = |(nib_chg & ~wake_ctrl_q[3:0]);
	wire [7:0] src_evt = {port_evt, timer_underflow_i, ext_irq_one_evt, ext_irq_zero_evt, tick_ovf};
	wire [7:0] mode_src = running ? reset_wake_tick_watchdog_pkg::IRQ_RUN_SRC :
		(in_idle ? reset_wake_tick_watchdog_pkg::IDLE_SRC : reset_wake_tick_watchdog_pkg::SLEEP_SRC);
	wire [7:0] flag_set = src_evt & mode_src & int_mask_q;
	// Port change wakes regardless of its mask; others wake only when enabled
	wire [7:0] wake_en = int_mask_q | (8'h01 << reset_wake_tick_watchdog_pkg::FLG_PORT);
	wire wake_evt = ~running & |(src_evt & mode_src & wake_en);
	wire port_jump = ~running & port_evt & int_mask_q[reset_wake_tick_watchdog_pkg::FLG_PORT];
	wire [7:0] flags_d = (wr_flags ? req_i.wdata : int_flags_q) | flag_set;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Global-interrupt bit mirrors the core but is held low while in reset
	wire [7:0] tctl_rd = {tick_ctrl_q[7], gie_i & ~reset_q, tick_ctrl_q[5:0]};
	wire [7:0] rd_mux =
		reg_hit(req_i, 1'b0, 1'b0, reset_wake_tick_watchdog_pkg::ADDR_TICK_COUNT) ? tick_count_q :
		reg_hit(req_i, 1'b0, 1'b0, reset_wake_tick_watchdog_pkg::ADDR_INT_FLAGS) ? int_flags_q :
		reg_hit(req_i, 1'b1, 1'b0, reset_wake_tick_watchdog_pkg::ADDR_INT_MASK) ? int_mask_q :
		reg_hit(req_i, 1'b1, 1'b1, reset_wake_tick_watchdog_pkg::ADDR_WAKE_CTRL) ? wake_ctrl_q :
		reg_hit(req_i, 1'b1, 1'b1, reset_wake_tick_watchdog_pkg::ADDR_TICK_CTRL) ? tctl_rd :
		reg_hit(req_i, 1'b1, 1'b1, reset_wake_tick_watchdog_pkg::ADDR_WDOG_CTRL) ? wdog_ctrl_q :
		reset_wake_tick_watchdog_pkg::ZERO_BYTE;

	// ----------------------------------------------------------------
	// Reset sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		reset_q <= srst_i | rst_cause;
		por_q <= srst_i;
		if (clr)
			osc_run_q <= 1'b1;
		else if (sleep_instr_i)
			osc_run_q <= 1'b0;
		else if (wake_evt)
			osc_run_q <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Sampling of pins
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		pin_s1_q <= tick_pin_i;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
		ext_prev_q <= {ext_irq_one_i, ext_irq_zero_i};
		port_prev_q <= port_now;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (clr) begin
			tick_ctrl_q <= reset_wake_tick_watchdog_pkg::TICK_CTRL_RST;
			wdog_ctrl_q <= reset_wake_tick_watchdog_pkg::WDOG_CTRL_RST;
			wake_ctrl_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
			int_mask_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
			int_flags_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
		end else begin
			if (wr_tctl)
				tick_ctrl_q <= req_i.wdata;
			if (wr_wctl)
				wdog_ctrl_q <= req_i.wdata & reset_wake_tick_watchdog_pkg::WDOG_CTRL_WMASK;
			if (wr_wake)
				wake_ctrl_q <= req_i.wdata & reset_wake_tick_watchdog_pkg::WAKE_CTRL_WMASK;
			if (wr_mask)
				int_mask_q <= req_i.wdata;
			// A source event in the clearing write's cycle still sets its flag
			int_flags_q <= flags_d;
		end
	end

	// ----------------------------------------------------------------
	// Tick counter and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (clr) begin
			tick_count_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
			tick_pre_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
		end else if (wr_tick) begin
			tick_count_q <= req_i.wdata;
			tick_pre_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
		end else begin
			if (tick_evt)
				tick_pre_q <= tick_pre_q + reset_wake_tick_watchdog_pkg::ONE_BYTE;
			if (tick_inc)
				tick_count_q <= tick_count_q + reset_wake_tick_watchdog_pkg::ONE_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog, clocked by sub-oscillator strobes so main clock gating is irrelevant
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (clr) begin
			half_q <= 1'b0;
			wdt_pre_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
			wdt_cnt_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
		end else begin
			if (sub_osc_tick_i)
				half_q <= ~half_q;
			if (wdt_pre_clr)
				wdt_pre_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
			else if (fs_half_tick)
				wdt_pre_q <= wdt_pre_q + reset_wake_tick_watchdog_pkg::ONE_BYTE;
			// Disabled watchdog holds at zero so enabling never fires at once
			if (wdt_clr_instr_i || !wdt_en)
				wdt_cnt_q <= reset_wake_tick_watchdog_pkg::ZERO_BYTE;
			else if (wdt_step)
				wdt_cnt_q <= wdt_cnt_q + reset_wake_tick_watchdog_pkg::ONE_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// Outputs to the core
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		ctl_q.reset <= srst_i | rst_cause;
		ctl_q.dir_all_in <= srst_i | rst_cause;
		ctl_q.osc_run <= srst_i | rst_cause | osc_run_q;
		ctl_q.por_clear <= por_q & ~srst_i;
		ctl_q.pc_load <= srst_i | rst_cause | (port_jump & ~clr);
		ctl_q.pc_value <= (srst_i | rst_cause) ? reset_wake_tick_watchdog_pkg::PC_RESET :
			reset_wake_tick_watchdog_pkg::PC_WAKE_VECTOR;
		ctl_q.wake <= wake_evt & ~clr;
		ctl_q.irq_req <= ~clr & |(int_flags_q & int_mask_q);
		rdata_q <= (req_i.rd & ~srst_i) ? rd_mux : reset_wake_tick_watchdog_pkg::ZERO_BYTE;
	end

	assign ctl_o = ctl_q;
	assign rdata_o = rdata_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	property p_tick_pre_clear;
		wr_tick && !clr |=> tick_pre_q == 8'h00;
	endproperty
	a_tick_pre_clear: assert property (p_tick_pre_clear) else $error("tick prescaler not cleared");

	property p_wdt_pre_clear;
		(wdt_clr_instr_i || sleep_instr_i) && !clr |=> wdt_pre_q == 8'h00;
	endproperty
	a_wdt_pre_clear: assert property (p_wdt_pre_clear) else $error("watchdog prescaler not cleared");

	property p_tick_inc;
		!clr && !wr_tick && instr_tick_i && !tick_ctrl_q[reset_wake_tick_watchdog_pkg::TC_SRC]
			&& !tick_ctrl_q[reset_wake_tick_watchdog_pkg::TC_PRESCALER_ASSIGN_BIT]
			|=> tick_count_q == 8'($past(tick_count_q) + 8'h01);
	endproperty
	a_tick_inc: assert property (p_tick_inc) else $error("tick count missed a cycle");

	property p_wdt_reset;
		wdt_expire |=> ctl_o.reset ##1 (wdt_cnt_q == 8'h00 && tick_count_q == 8'h00);
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog expiry without reset");

	property p_pin_reset;
		!ext_reset_n_i |=> ctl_o.reset && ctl_o.dir_all_in && ctl_o.pc_load && ctl_o.pc_value == 13'h0000;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");

	property p_ctrl_reset;
		reset_q && !rst_cause |=> tick_ctrl_q == reset_wake_tick_watchdog_pkg::TICK_CTRL_RST
			&& wdog_ctrl_q == reset_wake_tick_watchdog_pkg::WDOG_CTRL_RST && tick_pre_q == 8'h00;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset values wrong");

	property p_por_clear;
		$fell(srst_i) |=> ctl_o.por_clear;
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("power-on clear missing");

	property p_tick_no_wake;
		!running && !wr_flags && !clr |=> !(int_flags_q[0] && !$past(int_flags_q[0]));
	endproperty
	a_tick_no_wake: assert property (p_tick_no_wake) else $error("tick flag set while stopped");

	property p_port_wake;
		in_sleep && port_evt && !clr |=> ctl_o.wake;
	endproperty
	a_port_wake: assert property (p_port_wake) else $error("port change did not wake");

	property p_timer_sleep;
		in_sleep && |timer_underflow_i && !port_evt && !ext_irq_zero_evt && !ext_irq_one_evt |=> !ctl_o.wake;
	endproperty
	a_timer_sleep: assert property (p_timer_sleep) else $error("timer woke from sleep");

	property p_port_jump;
		port_jump && !clr && !rst_cause
			|=> ctl_o.pc_load && ctl_o.pc_value == reset_wake_tick_watchdog_pkg::PC_WAKE_VECTOR;
	endproperty
	a_port_jump: assert property (p_port_jump) else $error("port change did not jump");

	// Only the falling-edge pin is checked; the other pin shares the same wake path
	property p_irq_pin_wake;
		!running && ext_irq_one_evt && int_mask_q[reset_wake_tick_watchdog_pkg::FLG_EXT_IRQ_ONE] && !clr
			|=> ctl_o.wake;
	endproperty
	a_irq_pin_wake: assert property (p_irq_pin_wake) else $error("pin interrupt did not wake");

endmodule : reset_wake_tick_watchdog

`default_nettype wire

// ---- hw/reset_wake_tick_watchdog_pkg.sv ----
// Shared constants and carriers for the reset, wake, tick counter and watchdog block.
// Assumes one core-side register port addressed by file space, page and 4-bit offset.
package reset_wake_tick_watchdog_pkg;

	// ----------------------------------------------------------------
	// Register offsets (tick and flags in the data file, rest in control space)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_TICK_COUNT = 4'h1;
	localparam logic [3:0] ADDR_INT_FLAGS = 4'hf;
	localparam logic [3:0] ADDR_INT_MASK = 4'hf;
	localparam logic [3:0] ADDR_WAKE_CTRL = 4'h6;
	localparam logic [3:0] ADDR_TICK_CTRL = 4'h7;
	localparam logic [3:0] ADDR_WDOG_CTRL = 4'h8;

	// ----------------------------------------------------------------
	// Reset values and writable bits
	// ----------------------------------------------------------------
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [7:0] FULL_BYTE = 8'hff;
	localparam logic [7:0] TICK_CTRL_RST = 8'hbf;
	localparam logic [7:0] WDOG_CTRL_RST = 8'h07;
	localparam logic [7:0] WAKE_CTRL_WMASK = 8'h8f;
	localparam logic [7:0] WDOG_CTRL_WMASK = 8'h0f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TC_INT_EDGE = 7;
	localparam int TC_GIE = 6;
	localparam int TC_SRC = 5;
	localparam int TC_EDGE = 4;
	localparam int TC_PRESCALER_ASSIGN_BIT = 3;
	localparam int WD_EN = 3;
	localparam int PSEL_HI = 2;
	localparam int PSEL_LO = 0;
	localparam int FLG_TICK = 0;
	localparam int FLG_EXT_IRQ_ZERO = 1;
	localparam int FLG_EXT_IRQ_ONE = 2;
	localparam int FLG_TMR_LO = 3;
	localparam int FLG_TMR_HI = 6;
	localparam int FLG_PORT = 7;

	// ----------------------------------------------------------------
	// Which sources act in which mode
	// ----------------------------------------------------------------
	localparam logic [7:0] IRQ_RUN_SRC = 8'h7f;
	localparam logic [7:0] IDLE_SRC = 8'hfe;
	localparam logic [7:0] SLEEP_SRC = 8'h86;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_WAKE_VECTOR = 13'h0018;

	typedef enum logic [1:0] {MODE_NORMAL, MODE_GREEN, MODE_IDLE, MODE_SLEEP} op_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic ioc;
		logic page;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic reset;
		logic dir_all_in;
		logic osc_run;
		logic por_clear;
		logic pc_load;
		logic [12:0] pc_value;
		logic wake;
		logic irq_req;
	} core_ctl_t;

endpackage : reset_wake_tick_watchdog_pkg

// ---- tb/core_pins_model.sv ----
// Partner model of the core side: instruction strobes and sub-oscillator strobes.
// Assumes one clock; strobes change just after the rising edge.
`timescale 1ns/1ps
`default_nettype none

module core_pins_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Control
	input wire logic instr_en_i,
	// Strobes
	output logic instr_tick_o,
	output logic sub_osc_tick_o
);
	logic [1:0] div_q;
	logic [1:0] div_d;

	// ----------------------------------------------------------------
	// Strobes
	// ----------------------------------------------------------------
	// Instruction cycle is three clocks, so the tick counter sees sparse pulses
	assign div_d = (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;

	always_ff @(posedge mclk_i) begin
		div_q <= srst_i ? 2'h0 : div_d;
		instr_tick_o <= !srst_i && instr_en_i && (div_q == 2'h0);
		sub_osc_tick_o <= !srst_i && !sub_osc_tick_o;
	end
endmodule : core_pins_model

`default_nettype wire

// ---- tb/reset_wake_tick_watchdog_test.sv ----
// Self-checking bench for the reset, wake, tick counter and watchdog block.
// Assumes the core_pins_model partner supplies instruction and sub-oscillator strobes.
`timescale 1ns/1ps
`default_nettype none

module reset_wake_tick_watchdog_test;
	// ----------------------------------------------------------------
	// Stimulus and model state
	// ----------------------------------------------------------------
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	reset_wake_tick_watchdog_pkg::reg_req_t req = '0;
	reset_wake_tick_watchdog_pkg::op_mode_t mode = reset_wake_tick_watchdog_pkg::MODE_NORMAL;
	reset_wake_tick_watchdog_pkg::core_ctl_t ctl;
	logic [7:0] rdata, b;
	logic [15:0] pt = 16'h0000;
	logic [3:0] tuf = 4'h0;
	logic ins, sub, ins_en = 1'b0, clr = 1'b0, slp = 1'b0, pin = 1'b0;
	logic ei0 = 1'b0, ei1 = 1'b1, rst_n = 1'b1, lvd = 1'b0;
	int miscompares = 0, checked = 0, cycles = 0, n = 0, n0, m, r;
	// Reset image: ioc, page, offset, value
	logic [13:0] dflt [7] = '{14'h0100, 14'h0f00, 14'h0300, 14'h2f00, 14'h3600, 14'h37bf, 14'h3807};

	reset_wake_tick_watchdog reset_wake_tick_watchdog_i (.mclk_i(mclk_i), .srst_i(srst_i),
		.req_i(req), .instr_tick_i(ins), .wdt_clr_instr_i(clr), .sleep_instr_i(slp),
		.gie_i(1'b0), .mode_i(mode), .rdata_o(rdata), .ctl_o(ctl), .ext_reset_n_i(rst_n),
		.low_voltage_det_i(lvd), .low_voltage_reset_en_i(lvd), .sub_osc_tick_i(sub),
		.tick_pin_i(pin), .ext_irq_zero_i(ei0), .ext_irq_one_i(ei1),
		.timer_underflow_i(tuf), .port6_i(pt[7:0]), .port8_i(pt[15:8]));

	core_pins_model core_pins_model_i (.mclk_i(mclk_i), .srst_i(srst_i), .instr_en_i(ins_en),
		.instr_tick_o(ins), .sub_osc_tick_o(sub));

	initial forever #2 mclk_i = !mclk_i;

	// Instruction pulses are counted here, as the core would see them
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (ins) n <= n + 1;
		if (cycles == 20000) begin
			miscompares++;
			finish_test;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp8

	task automatic cmp1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t flag got %h exp %h", $time, got, exp);
		end
	endtask : cmp1

	task automatic finish_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	// One-cycle strobe; read data is registered at the sampling edge
	task automatic bus(input logic w, input logic i, input logic pg, input logic [3:0] a,
			input logic [7:0] d);
		@(posedge mclk_i);
		req <= '{w, !w, i, pg, a, d};
		@(posedge mclk_i);
		req <= '0;
		#1;
	endtask : bus

	task automatic rd_cmp(input logic i, input logic pg, input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, i, pg, a, 8'h00);
		cmp8(rdata, e);
	endtask : rd_cmp

	task automatic rd_dflt;
		foreach (dflt[j]) rd_cmp(dflt[j][13], dflt[j][12], dflt[j][11:8], dflt[j][7:0]);
	endtask : rd_dflt

	// Reset must stay low for q cycles, then rise within w more
	task automatic rst_chk(input int q, input int w);
		logic hit;
		hit = 1'b0;
		for (int c = 0; c < q + w; c++) begin
			@(posedge mclk_i);
			#1;
			hit = hit | ctl.reset;
			if (c == q - 1) cmp1(hit, 1'b0);
		end
		if (w > 0) begin
			cmp1(hit, 1'b1);
			repeat (10) @(posedge mclk_i);
			#1;
			cmp1(ctl.reset, 1'b0);
		end
	endtask : rst_chk

	task automatic wk(input logic [1:0] md, input logic [7:0] mk, input int kind, input int bt,
			input logic e);
		logic seen, jmp;
		seen = 1'b0;
		jmp = 1'b0;
		mode <= reset_wake_tick_watchdog_pkg::op_mode_t'(md);
		bus(1'b1, 1'b1, 1'b0, 4'hf, mk);
		@(posedge mclk_i);
		case (kind)
			0: pt <= pt ^ (16'h0001 << bt);
			1: tuf <= 4'h1 << bt;
			2: ei0 <= !ei0;
			3: ei1 <= !ei1;
			default: ins_en <= 1'b1;
		endcase
		repeat (5) begin
			@(posedge mclk_i);
			tuf <= 4'h0;
			#1;
			seen = seen | ctl.wake;
			jmp = jmp | (ctl.pc_load && ctl.pc_value == 13'h0018);
		end
		ins_en <= 1'b0;
		cmp1(seen, e);
		cmp1(jmp, kind == 0 && mk[7] && e);
	endtask : wk

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h33adb136));
		repeat (6) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		cmp1(ctl.por_clear, 1'b1);
		rd_dflt;
		bus(1'b1, 1'b1, 1'b1, 4'h6, 8'hff);
		rd_cmp(1'b1, 1'b1, 4'h6, 8'h8f);
		bus(1'b1, 1'b1, 1'b1, 4'h6, 8'h00);
		bus(1'b1, 1'b1, 1'b1, 4'h8, 8'hf7);
		rd_cmp(1'b1, 1'b1, 4'h8, 8'h07);
		// Prescaler residue is left behind on purpose; the count write must drop it
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 1'b1, 1'b1, 4'h7, k ? 8'h08 | 8'(k - 1) : 8'h00);
			b = 8'($urandom);
			bus(1'b1, 1'b0, 1'b0, 4'h1, b);
			n0 = n;
			ins_en <= 1'b1;
			repeat (90) @(posedge mclk_i);
			ins_en <= 1'b0;
			repeat (4) @(posedge mclk_i);
			rd_cmp(1'b0, 1'b0, 4'h1, b + 8'((n - n0) >> k));
		end
		for (int e = 0; e < 2; e++) begin
			bus(1'b1, 1'b1, 1'b1, 4'h7, e ? 8'h30 : 8'h20);
			bus(1'b1, 1'b0, 1'b0, 4'h1, 8'h00);
			m = $urandom_range(20, 1);
			repeat (2 * m) begin
				@(posedge mclk_i);
				pin <= !pin;
				repeat (4) @(posedge mclk_i);
			end
			repeat (6) @(posedge mclk_i);
			rd_cmp(1'b0, 1'b0, 4'h1, 8'(m));
		end
		bus(1'b1, 1'b1, 1'b0, 4'hf, 8'h01);
		bus(1'b1, 1'b1, 1'b1, 4'h7, 8'h00);
		bus(1'b1, 1'b0, 1'b0, 4'h1, 8'hff);
		ins_en <= 1'b1;
		repeat (6) @(posedge mclk_i);
		ins_en <= 1'b0;
		rd_cmp(1'b0, 1'b0, 4'hf, 8'h01);
		cmp1(ctl.irq_req, 1'b1);
		bus(1'b1, 1'b0, 1'b0, 4'hf, 8'h00);
		bus(1'b1, 1'b0, 1'b0, 4'h1, 8'hff);
		wk(2'd2, 8'h01, 4, 0, 1'b0);
		r = $urandom_range(3, 0);
		wk(2'd3, 8'h00, 0, r, 1'b1);
		wk(2'd0, 8'h80, 0, r, 1'b0);
		bus(1'b1, 1'b1, 1'b1, 4'h6, 8'h01);
		wk(2'd3, 8'h00, 0, r, 1'b0);
		wk(2'd3, 8'h00, 0, r + 4, 1'b1);
		wk(2'd3, 8'h78, 1, r, 1'b0);
		wk(2'd2, 8'h78, 1, r, 1'b1);
		wk(2'd3, 8'h02, 2, 0, 1'b1);
		wk(2'd2, 8'h04, 3, 0, 1'b1);
		wk(2'd3, 8'h80, 0, r + 8, 1'b1);
		rd_cmp(1'b0, 1'b0, 4'hf, 8'h86 | (8'h08 << r));
		cmp8(ctl.pc_value[7:0], 8'h18);
		mode <= reset_wake_tick_watchdog_pkg::MODE_NORMAL;
		for (int s = 0; s < 2; s++) begin
			@(posedge mclk_i);
			if (s == 0) rst_n <= 1'b0;
			else lvd <= 1'b1;
			repeat (3) @(posedge mclk_i);
			#1;
			cmp1(ctl.reset & ctl.dir_all_in & ctl.osc_run, 1'b1);
			cmp8(ctl.pc_value[7:0], 8'h00);
			rst_n <= 1'b1;
			lvd <= 1'b0;
			repeat (4) @(posedge mclk_i);
			rd_dflt;
		end
		bus(1'b1, 1'b1, 1'b1, 4'h8, 8'h08);
		rst_chk(600, 0);
		@(posedge mclk_i);
		clr <= 1'b1;
		@(posedge mclk_i);
		clr <= 1'b0;
		rst_chk(1019, 14);
		rd_dflt;
		bus(1'b1, 1'b1, 1'b1, 4'h8, 8'h08);
		mode <= reset_wake_tick_watchdog_pkg::MODE_SLEEP;
		@(posedge mclk_i);
		slp <= 1'b1;
		@(posedge mclk_i);
		slp <= 1'b0;
		rst_chk(1100, 0);
		cmp1(ctl.osc_run, 1'b0);
		bus(1'b1, 1'b1, 1'b1, 4'h8, 8'h00);
		mode <= reset_wake_tick_watchdog_pkg::MODE_NORMAL;
		rst_chk(1100, 0);
		finish_test;
	end
endmodule : reset_wake_tick_watchdog_test

`default_nettype wire
